/* File: ltt_timers.sv */
// What this block does
// R01: link timeout lasts the 24-bit timeout value times 32 reference cycles
// R02: link timeout runs from packet or link-request sent until answer arrives
// R03: link timeout value resets to all ones
// R04: silence done after about 120 us of enable in SILENT; low outside SILENT
// R05: silence timer is a fixed cycle count with no programmable setting
// R06: discovery done after held enable in DISCOVERY; low outside that state
// R07: discovery period is prescale times 131071 reference cycles on four-lane ports, 131071 cycles on single-lane ports
// R08: discovery prescale resets to nine and stays writable
// R09: discovery prescale applies to four-lane ports
// R10: every silence detection while enabled reloads the dead-link counter from threshold
// R11: dead-link duration is 8192 cycles times the 15-bit threshold
// R12: dead-link threshold resets to all ones
// R13: count at zero declares link dead, flushes queue, blocks until link up
// R14: while dead, packets routed to the port are dropped
// R15: dead-link detection runs only when enabled
// R16: I2C timebase derives from the reference clock
// R17: I2C timing written during boot load applies only after it ends
// R18: microsecond tick period is reference period times divider plus one
// R19: millisecond tick period is microsecond period times divider plus one
// R20: dividers are cascaded counters with one-cycle terminal pulses
// R21: each timeout counter restarts when its enabling condition goes away
`timescale 1ns/100ps
`default_nettype none
module ltt_timers
   import ltt_pkg::*;
#(
   parameter int unsigned SIL_CYC   = SILENCE_CYC,
   parameter int unsigned DISC_CYC  = DISC_STEP_CYC,
   parameter int unsigned DEAD_CYC  = DEAD_PRE_CYC
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata_q,
   // link timeout
   input  wire logic        lto_start,
   input  wire logic        lto_stop,
   output logic             link_timeout_q,
   // silence and discovery
   input  wire logic        silence_timer_en,
   input  wire logic        state_silent,
   output logic             silence_done_q,
   input  wire logic        discovery_timer_en,
   input  wire logic        state_discovery,
   input  wire logic        port_4x,
   output logic             discovery_done_q,
   // dead link
   input  wire logic        silence_detected,
   input  wire logic        link_up,
   output logic             link_dead_q,
   output logic             tx_flush_q,
   // i2c timebase
   input  wire logic        boot_loading,
   output logic             us_tick,
   output logic             ms_tick
);
   localparam int unsigned SW = $clog2(SIL_CYC + 1);
   localparam int unsigned QW = $clog2(DISC_CYC);
   localparam int unsigned PW = $clog2(DEAD_CYC);
   localparam int unsigned LW = $clog2(LINK_PRE_CYC);
   initial begin
      if (SIL_CYC < 2) $error("ltt_timers: silence count too small");
      if (DISC_CYC < 2) $error("ltt_timers: discovery step too small");
      if (DEAD_CYC < 2) $error("ltt_timers: dead-link step too small");
   end
   // ==========================================
   // registers
   logic [LINK_TIMEOUT_VALUE_W-1:0] link_timeout_value_q;
   logic [DIV_W-1:0]  microsecond_divider_q;
   logic [DIV_W-1:0]  millisecond_divider_q;
   logic [DIV_W-1:0]  microsecond_divider_act_q;
   logic [DIV_W-1:0]  millisecond_divider_act_q;
   logic [DISC_W-1:0] disc_pre_q;
   logic [DLT_W-1:0]  dead_thresh_q;
   logic              dead_en_q;

   // R03: timeout value reset
   // R08: prescale reset nine
   // R12: threshold reset all ones
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         link_timeout_value_q        <= LINK_TIMEOUT_VALUE_RST;
         microsecond_divider_q       <= MICROSECOND_DIVIDER_RST;
         millisecond_divider_q       <= MILLISECOND_DIVIDER_RST;
         disc_pre_q    <= DISC_RST;
         dead_thresh_q <= DLT_RST;
         dead_en_q     <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFF_LINK_TO: link_timeout_value_q <= reg_wdata[LINK_TIMEOUT_VALUE_LSB +: LINK_TIMEOUT_VALUE_W];
            OFF_I2C_DIV: begin
               microsecond_divider_q <= reg_wdata[MICROSECOND_DIVIDER_LSB +: DIV_W];
               millisecond_divider_q <= reg_wdata[MILLISECOND_DIVIDER_LSB +: DIV_W];
            end
            OFF_DISC: disc_pre_q <= reg_wdata[DISC_W-1:0];
            OFF_DEAD: begin
               dead_thresh_q <= reg_wdata[DLT_W-1:0];
               dead_en_q     <= reg_wdata[DEAD_EN_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // R17: shadowed dividers frozen
   // the running boot load keeps the timing it started with
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         microsecond_divider_act_q <= MICROSECOND_DIVIDER_RST;
         millisecond_divider_act_q <= MILLISECOND_DIVIDER_RST;
      end else if (!boot_loading) begin
         microsecond_divider_act_q <= microsecond_divider_q;
         millisecond_divider_act_q <= millisecond_divider_q;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= '0;
      end else if (reg_rd) begin
         reg_rdata_q <= '0;
         unique case (reg_addr)
            OFF_LINK_TO: reg_rdata_q[LINK_TIMEOUT_VALUE_LSB +: LINK_TIMEOUT_VALUE_W] <= link_timeout_value_q;
            OFF_I2C_DIV: begin
               reg_rdata_q[MICROSECOND_DIVIDER_LSB +: DIV_W] <= microsecond_divider_q;
               reg_rdata_q[MILLISECOND_DIVIDER_LSB +: DIV_W] <= millisecond_divider_q;
            end
            OFF_DISC: reg_rdata_q[DISC_W-1:0] <= disc_pre_q;
            OFF_DEAD: begin
               reg_rdata_q[DLT_W-1:0]    <= dead_thresh_q;
               reg_rdata_q[DEAD_EN_BIT] <= dead_en_q;
               reg_rdata_q[DEAD_ST_BIT] <= link_dead_q;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // divider stages
   ltt_div_if #(.W(DIV_W)) us_if ();
   ltt_div_if #(.W(DIV_W)) ms_if ();
   ltt_div_if #(.W(LW))    lp_if ();
   ltt_div_if #(.W(QW))    qp_if ();
   ltt_div_if #(.W(PW))    dp_if ();

   ltt_tick_div #(.W(DIV_W)) u_us (.clock(clock), .arst_n(arst_n), .dv(us_if));
   ltt_tick_div #(.W(DIV_W)) u_ms (.clock(clock), .arst_n(arst_n), .dv(ms_if));
   ltt_tick_div #(.W(LW))    u_lp (.clock(clock), .arst_n(arst_n), .dv(lp_if));
   ltt_tick_div #(.W(QW))    u_qp (.clock(clock), .arst_n(arst_n), .dv(qp_if));
   ltt_tick_div #(.W(PW))    u_dp (.clock(clock), .arst_n(arst_n), .dv(dp_if));

   // R16: reference clock timebase
   // R18: microsecond stage
   assign us_if.step = 1'b1;
   assign us_if.clr  = 1'b0;
   assign us_if.div  = microsecond_divider_act_q;
   // R19: millisecond stage
   // R20: cascade on terminal pulse
   assign ms_if.step = us_if.tick;
   assign ms_if.clr  = 1'b0;
   assign ms_if.div  = millisecond_divider_act_q;
   assign us_tick    = us_if.tick;
   assign ms_tick    = ms_if.tick;

   // ==========================================
   // link timeout
   logic              lto_run_q;
   logic [LINK_TIMEOUT_VALUE_W:0]   lto_cnt_q;

   // R01: 32-cycle prescale
   assign lp_if.step = lto_run_q;
   // R21: restart on stop
   assign lp_if.clr  = !lto_run_q || lto_start;
   assign lp_if.div  = LW'(LINK_PRE_CYC - 1);

   // R02: start on send, stop on answer
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lto_run_q      <= 1'b0;
         lto_cnt_q      <= '0;
         link_timeout_q <= 1'b0;
      end else begin
         link_timeout_q <= 1'b0;
         if (lto_start) begin
            lto_run_q <= 1'b1;
            lto_cnt_q <= '0;
         end else if (lto_stop) begin
            lto_run_q <= 1'b0;
         end else if (lto_run_q && lp_if.tick) begin
            if (lto_cnt_q + (LINK_TIMEOUT_VALUE_W+1)'(1) >= {1'b0, link_timeout_value_q}) begin
               link_timeout_q <= 1'b1;
               lto_run_q      <= 1'b0;
            end else begin
               lto_cnt_q <= lto_cnt_q + (LINK_TIMEOUT_VALUE_W+1)'(1);
            end
         end
      end
   end

   // ==========================================
   // silence timer
   logic [SW-1:0] sil_cnt_q;

   // R05: fixed count, no setting
   // R04: done only in SILENT
   // R21: restart when enable drops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sil_cnt_q      <= '0;
         silence_done_q <= 1'b0;
      end else begin
         if (!state_silent) begin
            silence_done_q <= 1'b0;
         end else if (silence_timer_en && sil_cnt_q == SW'(SIL_CYC - 1)) begin
            silence_done_q <= 1'b1;
         end
         if (!(silence_timer_en && state_silent) || silence_done_q) begin
            sil_cnt_q <= '0;
         end else if (sil_cnt_q != SW'(SIL_CYC - 1)) begin
            sil_cnt_q <= sil_cnt_q + SW'(1);
         end
      end
   end

   // ==========================================
   // discovery timer
   logic              disc_active;
   logic [DISC_W-1:0] disc_target;
   logic [DISC_W:0]   disc_cnt_q;

   assign disc_active = discovery_timer_en && state_discovery;
   // R09: prescale only in four-lane mode
   // a single-lane port takes one step, as the prescale has no use there
   assign disc_target = port_4x ? disc_pre_q : DISC_W'(1);
   // R07: 131071-cycle step
   assign qp_if.step  = disc_active && !discovery_done_q;
   // R21: restart when enable drops
   assign qp_if.clr   = !disc_active;
   assign qp_if.div   = QW'(DISC_CYC - 1);

   // R06: done only in DISCOVERY
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         disc_cnt_q       <= '0;
         discovery_done_q <= 1'b0;
      end else begin
         if (!state_discovery) begin
            discovery_done_q <= 1'b0;
         end
         if (!disc_active) begin
            disc_cnt_q <= '0;
         end else if (qp_if.tick && !discovery_done_q) begin
            if (disc_cnt_q + (DISC_W+1)'(1) >= {1'b0, disc_target}) begin
               discovery_done_q <= 1'b1;
            end else begin
               disc_cnt_q <= disc_cnt_q + (DISC_W+1)'(1);
            end
         end
      end
   end

   // ==========================================
   // dead link timer
   logic             dead_run_q;
   logic [DLT_W-1:0] dead_cnt_q;
   logic             dead_reload;
   logic             dead_hit;

   // R15: only when enabled
   assign dead_reload = silence_detected && dead_en_q;
   assign dead_hit    = dead_run_q && dp_if.tick && !dead_reload && dead_cnt_q <= DLT_W'(1);
   // R11: 8192-cycle step
   assign dp_if.step  = dead_run_q;
   assign dp_if.clr   = !dead_run_q || dead_reload;
   assign dp_if.div   = PW'(DEAD_CYC - 1);

   // R10: reload on each silence
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dead_run_q <= 1'b0;
         dead_cnt_q <= '0;
      end else if (dead_reload) begin
         dead_run_q <= 1'b1;
         dead_cnt_q <= dead_thresh_q;
      end else if (!dead_en_q || link_up || dead_hit) begin
         // R21: stop when disabled
         dead_run_q <= 1'b0;
         dead_cnt_q <= '0;
      end else if (dead_run_q && dp_if.tick) begin
         dead_cnt_q <= dead_cnt_q - DLT_W'(1);
      end
   end

   // R13: declare dead, flush queue
   // R14: dead level drops routed packets
   // a declaration in the same cycle as link up wins, so no event is lost
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         link_dead_q <= 1'b0;
         tx_flush_q  <= 1'b0;
      end else begin
         tx_flush_q <= dead_hit;
         if (dead_hit) begin
            link_dead_q <= 1'b1;
         end else if (link_up) begin
            link_dead_q <= 1'b0;
         end
      end
   end
   // ==========================================
   // checks
   property p_sil_low;
      @(posedge clock) disable iff (!arst_n)
      !state_silent |=> !silence_done_q;
   endproperty
   a_sil_low: assert property (p_sil_low) else $error("silence done outside SILENT"); // R04
   property p_sil_len;
      @(posedge clock) disable iff (!arst_n)
      $rose(silence_done_q) |-> $past(sil_cnt_q) == SW'(SIL_CYC - 1) && $past(silence_timer_en);
   endproperty
   a_sil_len: assert property (p_sil_len) else $error("silence done early"); // R05
   property p_disc_low;
      @(posedge clock) disable iff (!arst_n)
      !state_discovery |=> !discovery_done_q;
   endproperty
   a_disc_low: assert property (p_disc_low) else $error("discovery done outside DISCOVERY"); // R06
   property p_disc_step;
      @(posedge clock) disable iff (!arst_n)
      $rose(discovery_done_q) |-> $past(qp_if.tick);
   endproperty
   a_disc_step: assert property (p_disc_step) else $error("discovery done off step"); // R07
   property p_dead_reload;
      @(posedge clock) disable iff (!arst_n)
      dead_reload |=> dead_run_q && dead_cnt_q == $past(dead_thresh_q);
   endproperty
   a_dead_reload: assert property (p_dead_reload) else $error("dead counter not reloaded"); // R10
   property p_dead_flush;
      @(posedge clock) disable iff (!arst_n)
      $rose(link_dead_q) |-> tx_flush_q ##1 !tx_flush_q;
   endproperty
   a_dead_flush: assert property (p_dead_flush) else $error("dead without one flush pulse"); // R13
   property p_dead_off;
      @(posedge clock) disable iff (!arst_n)
      !dead_en_q && !$past(dead_en_q) |-> !dead_run_q;
   endproperty
   a_dead_off: assert property (p_dead_off) else $error("dead timer runs disabled"); // R15
   property p_shadow;
      @(posedge clock) disable iff (!arst_n)
      boot_loading |=> $stable(microsecond_divider_act_q) && $stable(millisecond_divider_act_q);
   endproperty
   a_shadow: assert property (p_shadow) else $error("divider changed during boot"); // R17
   property p_lto_run;
      @(posedge clock) disable iff (!arst_n)
      link_timeout_q |-> $past(lto_run_q) && !lto_run_q;
   endproperty
   a_lto_run: assert property (p_lto_run) else $error("timeout while idle"); // R02
endmodule
`default_nettype wire

/* File: ltt_pkg.sv */
`default_nettype none
package ltt_pkg;
   // ==========================================
   // clock and timing
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
   localparam int unsigned SILENCE_NS     = 120_000;
   // fixed length, no register: cycle count follows the reference clock frequency
   localparam int unsigned SILENCE_CYC    = (SILENCE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned LINK_PRE_CYC   = 32;
   localparam int unsigned DISC_STEP_CYC  = 131071;
   localparam int unsigned DEAD_PRE_CYC   = 8192;
   // ==========================================
   // register offsets
   localparam logic [7:0]  OFF_LINK_TO    = 8'h20;
   localparam logic [7:0]  OFF_I2C_DIV    = 8'h24;
   localparam logic [7:0]  OFF_DISC       = 8'h28;
   localparam logic [7:0]  OFF_DEAD       = 8'h2c;
   // ==========================================
   // field layout and reset values
   localparam int unsigned LINK_TIMEOUT_VALUE_LSB       = 8;
   localparam int unsigned LINK_TIMEOUT_VALUE_W         = 24;
   localparam logic [23:0] LINK_TIMEOUT_VALUE_RST       = 24'hffffff;
   localparam int unsigned DIV_W          = 12;
   localparam int unsigned MICROSECOND_DIVIDER_LSB      = 0;
   localparam int unsigned MILLISECOND_DIVIDER_LSB      = 16;
   localparam logic [11:0] MICROSECOND_DIVIDER_RST      = 12'h063;
   localparam logic [11:0] MILLISECOND_DIVIDER_RST      = 12'h3e7;
   localparam int unsigned DISC_W         = 4;
   localparam logic [3:0]  DISC_RST       = 4'h9;
   localparam int unsigned DLT_W          = 15;
   localparam logic [14:0] DLT_RST        = 15'h7fff;
   localparam int unsigned DEAD_EN_BIT    = 31;
   localparam int unsigned DEAD_ST_BIT    = 30;
endpackage
`default_nettype wire

/* File: ltt_div_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ltt_div_if #(parameter int unsigned W = 8);
   logic         step;
   logic         clr;
   logic [W-1:0] div;
   logic         tick;
   modport div_mp (input step, input clr, input div, output tick);
   modport user_mp (output step, output clr, output div, input tick);
endinterface
`default_nettype wire

/* File: ltt_tick_div.sv */
`timescale 1ns/100ps
`default_nettype none
module ltt_tick_div #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input  wire logic     clock,
   input  wire logic     arst_n,
   // divider stage
   ltt_div_if.div_mp     dv
);
   logic [W-1:0] cnt_q;
   logic         tick_q;

   initial begin
      if (W < 1) $error("ltt_tick_div: width must be at least one");
   end

   // ==========================================
   // one stage: period is div + 1 steps
   // a count above a lowered divider wraps at once, not after a full roll-over
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= dv.step && !dv.clr && (cnt_q >= dv.div);
         if (dv.clr) begin
            cnt_q <= '0;
         end else if (dv.step) begin
            if (cnt_q >= dv.div) begin
               cnt_q <= '0;
            end else begin
               cnt_q <= cnt_q + W'(1);
            end
         end
      end
   end

   assign dv.tick = tick_q;

   // ==========================================
   // checks
   property p_tick_step;
      @(posedge clock) disable iff (!arst_n)
      dv.tick |-> $past(dv.step) && !$past(dv.clr);
   endproperty
   a_tick_step: assert property (p_tick_step) else $error("tick without step"); // R20
   property p_tick_gap;
      @(posedge clock) disable iff (!arst_n)
      dv.tick && dv.div != '0 |=> !dv.tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks too close"); // R18
endmodule
`default_nettype wire

/* File: ltt_link_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// remote port: acknowledges sent packets after a delay, or never
module ltt_link_partner (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // commands from the bench
   input  wire logic       send,
   input  wire logic [7:0] ack_delay,
   input  wire logic       go_silent,
   // events seen by the timers
   output logic            lto_start,
   output logic            lto_stop,
   output logic            silence_detected
);
   logic [7:0] wait_q;

   // answer after delay
   // delay 0 models a partner that never answers
   always_ff @(negedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lto_start        <= 1'b0;
         lto_stop         <= 1'b0;
         silence_detected <= 1'b0;
         wait_q           <= 8'h00;
      end else begin
         lto_start        <= send;
         lto_stop         <= (wait_q == 8'h01);
         silence_detected <= go_silent;
         if (send) begin
            wait_q <= ack_delay;
         end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* File: ltt_timers_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ltt_timers_tb
   import ltt_pkg::*;
;
   // short counts keep the run small
   localparam int unsigned SIL = 10;
   localparam int unsigned DSC = 8;
   localparam int unsigned DED = 8;
   logic        clock, arst_n, reg_wr, reg_rd, boot_loading, send, go_silent;
   logic [7:0]  reg_addr, ack_delay;
   logic [31:0] reg_wdata, reg_rdata_q;
   logic        lto_start, lto_stop, silence_detected, link_timeout_q;
   logic        silence_timer_en, state_silent, silence_done_q;
   logic        discovery_timer_en, state_discovery, port_4x, discovery_done_q;
   logic        link_up, link_dead_q, tx_flush_q, us_tick, ms_tick;
   int          errors, samples_checked, n, p;

   ltt_timers #(.SIL_CYC(SIL), .DISC_CYC(DSC), .DEAD_CYC(DED)) ltt_timers_inst (
      .clock(clock), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .lto_start(lto_start), .lto_stop(lto_stop), .link_timeout_q(link_timeout_q),
      .silence_timer_en(silence_timer_en), .state_silent(state_silent),
      .silence_done_q(silence_done_q), .discovery_timer_en(discovery_timer_en),
      .state_discovery(state_discovery), .port_4x(port_4x), .discovery_done_q(discovery_done_q),
      .silence_detected(silence_detected), .link_up(link_up), .link_dead_q(link_dead_q),
      .tx_flush_q(tx_flush_q), .boot_loading(boot_loading), .us_tick(us_tick), .ms_tick(ms_tick));

   ltt_link_partner ltt_link_partner_inst (
      .clock(clock), .arst_n(arst_n), .send(send), .ack_delay(ack_delay), .go_silent(go_silent),
      .lto_start(lto_start), .lto_stop(lto_stop), .silence_detected(silence_detected));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ==========================================
   // checking and waiting
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // tol above zero accepts seen in exp .. exp+tol
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int unsigned tol = 0);
      samples_checked++;
      if ($isunknown(seen) || ((tol == 0) ? (seen !== exp) : (seen < exp || seen > exp + tol))) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic probe(input int k);
      case (k)
         0: probe = us_tick;
         1: probe = ms_tick;
         2: probe = lto_start;
         3: probe = link_timeout_q;
         4: probe = silence_done_q;
         5: probe = discovery_done_q;
         default: probe = link_dead_q;
      endcase
   endfunction

   // must=0 means running out of the bound is the expected outcome
   task automatic wait_for(input int k, input int bound, input bit must, output int cnt);
      cnt = 0;
      while (probe(k) !== 1'b1 && cnt < bound) begin
         @(negedge clock);
         #1;
         cnt++;
      end
      if (must && cnt >= bound) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
         conclude();
      end
   endtask

   task automatic period(input int k, output int cyc);
      int c;
      wait_for(k, 9000, 1, c);
      @(negedge clock);
      #1;
      wait_for(k, 9000, 1, c);
      cyc = c + 1;
   endtask

   // ==========================================
   // register port and partner commands
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(negedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(negedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(negedge clock);
      reg_rd <= 1'b0;
      check(reg_rdata_q, exp);
   endtask

   // 0 packet sent, 1 silence on the link, 2 link comes up
   task automatic strobe(input int k, input logic [7:0] dly);
      @(negedge clock);
      ack_delay <= dly;
      case (k)
         0: send <= 1'b1;
         1: go_silent <= 1'b1;
         default: link_up <= 1'b1;
      endcase
      @(negedge clock);
      send      <= 1'b0;
      go_silent <= 1'b0;
      link_up   <= 1'b0;
      #1;
   endtask

   // ==========================================
   // main sequence
   initial begin
      {errors, samples_checked} = '0;
      {arst_n, reg_wr, reg_rd, boot_loading, send, go_silent, link_up} = '0;
      {silence_timer_en, state_silent, discovery_timer_en, state_discovery, port_4x} = '0;
      {reg_addr, ack_delay, reg_wdata} = '0;
      repeat (16) @(negedge clock);
      arst_n <= 1'b1;
      rd(OFF_LINK_TO, {LINK_TIMEOUT_VALUE_RST, 8'h00});
      rd(OFF_I2C_DIV, {4'h0, MILLISECOND_DIVIDER_RST, 4'h0, MICROSECOND_DIVIDER_RST});
      rd(OFF_DISC, {28'h0, DISC_RST});
      rd(OFF_DEAD, {17'h0, DLT_RST});
      rd(8'h30, 32'h0);
      period(0, p);
      check(p, 32'(MICROSECOND_DIVIDER_RST) + 1);
      $display("test reset values finished");

      wr(OFF_I2C_DIV, {4'h0, 12'h002, 4'h0, 12'h004});
      period(0, p);
      check(p, 5);
      period(1, p);
      check(p, 15);
      @(negedge clock);
      boot_loading <= 1'b1;
      wr(OFF_I2C_DIV, {4'h0, 12'h002, 4'h0, 12'h009});
      rd(OFF_I2C_DIV, 32'h0002_0009);
      period(0, p);
      check(p, 5);
      @(negedge clock);
      boot_loading <= 1'b0;
      period(0, p);
      check(p, 10);
      period(1, p);
      check(p, 30);
      $display("test timebase finished");

      wr(OFF_LINK_TO, 32'h0000_0300);
      rd(OFF_LINK_TO, 32'h0000_0300);
      strobe(0, 8'h00);
      wait_for(2, 8, 1, n);
      wait_for(3, 200, 1, n);
      check(n, 95, 5);
      strobe(0, 8'h14);
      wait_for(3, 200, 0, n);
      check(n, 200);
      $display("test link timeout finished");

      // enable dropped mid-count must restart the window
      @(negedge clock);
      silence_timer_en <= 1'b1;
      state_silent     <= 1'b1;
      repeat (6) @(negedge clock);
      silence_timer_en <= 1'b0;
      @(negedge clock);
      silence_timer_en <= 1'b1;
      #1;
      wait_for(4, 40, 1, n);
      check(n, SIL - 1, 4);
      @(negedge clock);
      silence_timer_en <= 1'b0;
      state_silent     <= 1'b0;
      repeat (2) @(negedge clock);
      check(silence_done_q, 1'b0);
      $display("test silence finished");

      wr(OFF_DISC, 32'h5);
      rd(OFF_DISC, 32'h5);
      for (int m = 1; m >= 0; m--) begin
         @(negedge clock);
         port_4x            <= m[0];
         discovery_timer_en <= 1'b1;
         state_discovery    <= 1'b1;
         #1;
         wait_for(5, 100, 1, n);
         check(n, (m ? 5 : 1) * DSC - 1, 5);
         @(negedge clock);
         discovery_timer_en <= 1'b0;
         state_discovery    <= 1'b0;
         repeat (2) @(negedge clock);
         check(discovery_done_q, 1'b0);
      end
      $display("test discovery finished");

      wr(OFF_DEAD, 32'h0000_0003);
      strobe(1, 8'h00);
      wait_for(6, 60, 0, n);
      check(n, 60);
      wr(OFF_DEAD, 32'hc000_0003);
      rd(OFF_DEAD, 32'h8000_0003);
      strobe(1, 8'h00);
      repeat (16) @(negedge clock);
      strobe(1, 8'h00);
      wait_for(6, 60, 1, n);
      check(n, 3 * DED - 2, 5);
      check(tx_flush_q, 1'b1);
      rd(OFF_DEAD, 32'hc000_0003);
      check(tx_flush_q, 1'b0);
      strobe(2, 8'h00);
      @(negedge clock);
      check(link_dead_q, 1'b0);
      $display("test dead link finished");
      conclude();
   end
endmodule
`default_nettype wire
